/* uabir_pkg.sv */
// Constants, register map and carrier types for the auto-baud and infrared block
// Operation
// - Writing one to control bit 8 clears the completion flag; zero does nothing.
// - Writing one to control bit 9 clears the time-out flag; zero does nothing.
// - Setting the start bit begins measurement; clearing it early aborts it.
// - Start bit self-clears at finish; reading it shows pending or finished.
// - Mode 0 times falling edge of start bit to next falling edge.
// - Mode 1 times falling edge to next rising edge, start bit only.
// - Counter overflow is a time-out; auto-restart waits for next falling edge.
// - Time-out flag sets on overflow only when its enable is set.
// - Completion flag sets after divisor load only when its enable is set.
// - Start resets rate counter and shift register, baud input held low.
// - First falling edge after start marks start bit; counting begins there.
// - Sixteen clock-rate pulses feed the shift register baud input during start bit.
// - Stop edge loads count into divisor, then normal baud resumes.
// - Usable baud range bounded by counter width and character length.
// - Infrared control bit 0 selects standard or infrared encoding.
// - Infrared control bit 1 inverts serial input only, never the output.
// - Fixed width off gives transmit pulse of three sixteenths of bit.
// - Fixed width on: bits 5:3 pick power-of-two clock count pulse width.
// - Control bits 0 start, 1 mode, 2 auto-restart, all reset to zero.
// - Add value zero passes the clock undivided; multiplier must be at least 1.
package uabir_pkg;

    // Register byte addresses
    localparam logic [31:0] ADR_AUTOBAUD   = 32'h4000_8020;
    localparam logic [31:0] ADR_INFRARED   = 32'h4000_8024;
    localparam logic [31:0] ADR_FRACDIV    = 32'h4000_8028;
    localparam logic [31:0] ADR_DIVISOR    = 32'h4000_8040;
    localparam logic [31:0] ADR_IRQ_ENABLE = 32'h4000_8044;
    localparam logic [31:0] ADR_IRQ_FLAGS  = 32'h4000_8048;

    // Field positions
    localparam int AB_START_BIT   = 0;
    localparam int AB_MODE_BIT    = 1;
    localparam int AB_RESTART_BIT = 2;
    localparam int AB_END_CLR_BIT = 8;
    localparam int AB_TO_CLR_BIT  = 9;
    localparam int IR_EN_BIT      = 0;
    localparam int IR_INV_BIT     = 1;
    localparam int IR_FIX_BIT     = 2;
    localparam int IR_DIV_LSB     = 3;
    localparam int FD_MUL_LSB     = 4;
    localparam int IRQ_END_BIT    = 8;
    localparam int IRQ_TO_BIT     = 9;

    // Reset values and timing
    localparam logic [3:0]  FD_MUL_RESET  = 4'h1;
    localparam logic [15:0] DIV_RESET     = 16'h0001;
    localparam logic [3:0]  OVERSAMPLE_M1 = 4'hF;
    localparam logic [4:0]  BURST_PULSES  = 5'h10;
    localparam logic [4:0]  IR_RX_TICKS   = 5'h10;
    localparam logic [8:0]  IR_STD_TICKS  = 9'h003;
    localparam logic [8:0]  IR_FIX_BASE   = 9'h002;

    typedef struct packed {
        logic restart;
        logic mode;
        logic start;
    } uabir_ctrl_s;

    typedef struct packed {
        logic [2:0] div;
        logic       fix;
        logic       inv;
        logic       en;
    } uabir_ir_s;

    typedef struct packed {
        logic [3:0] mul;
        logic [3:0] add;
    } uabir_fd_s;

    typedef enum logic [1:0] {
        UABIR_IDLE,
        UABIR_WAIT_FALL,
        UABIR_MEASURE
    } uabir_state_e;

endpackage

/* uabir_terminal.sv */
// Remote serial terminal model driving the receive pin
`timescale 1ns/1ps
module uabir_terminal (
    // Clock
    input  wire logic clk_i,
    // Serial line toward the block
    output logic      rx_o
);
    // Line idles high between frames; the model drives it high from time zero
    initial rx_o = 1'h1;

    // One frame: start bit, eight data bits LSB first, stop bit
    task automatic send(input logic [7:0] ch, input int bit_clks);
        logic [9:0] frame;
        frame = {1'h1, ch, 1'h0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_i);
            rx_o <= frame[i];
            repeat (bit_clks - 1) @(posedge clk_i);
        end
    endtask
endmodule

/* uabir_top.sv */
// Auto-baud measurement, baud tick generation and infrared shaping with Wishbone slave
`timescale 1ns/1ps
module uabir_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Serial pins
    input  wire logic        rx_pin_i,
    output logic             tx_pin_o,
    // Rest of the USART
    input  wire logic        tx_serial_i,
    input  wire logic        tx_bit_start_i,
    output logic             rx_serial_o,
    output logic             rsr_baud_o,
    output logic             rsr_reset_o,
    output logic [15:0]      divisor_o,
    output logic             end_measure_irq_flag_o,
    output logic             timeout_irq_flag_o
);
    import uabir_pkg::*;

    uabir_ctrl_s  ctrl_ff;
    uabir_ir_s    ir_ff;
    uabir_fd_s    fd_ff;
    uabir_state_e state_ff;
    logic [15:0]  divisor_ff;
    logic         end_en_ff;
    logic         to_en_ff;
    logic         end_flag_ff;
    logic         to_flag_ff;
    logic         ack_ff;
    logic [31:0]  dat_ff;
    logic         rx_meta_ff;
    logic         rx_sync_ff;
    logic         rx_prev_ff;
    logic [4:0]   irx_cnt_ff;
    logic [3:0]   acc_ff;
    logic [15:0]  div_cnt_ff;
    logic [3:0]   rate_pre_ff;
    logic [15:0]  rate_cnt_ff;
    logic [4:0]   burst_ff;
    logic         rsr_reset_ff;
    logic [8:0]   pulse_cnt_ff;
    logic         tx_pin_ff;

    logic         wr_en;
    logic         rd_en;
    logic         rx_in;
    logic         rx_ser;
    logic         rx_fall;
    logic         rx_rise;
    logic [4:0]   acc_sum;
    logic         acc_wrap;
    logic         pre_tick;
    logic         baud16;
    logic         rate_tick;
    logic         overflow;
    logic         stop_edge;
    logic         done_ok;
    logic         done_to;
    logic         ab_busy;
    logic [15:0]  measured;
    logic [8:0]   fix_width;

    // Bus strobes: write commits on the edge where ack is seen by the master
    assign wr_en = cyc_i && stb_i && we_i && ack_ff;
    assign rd_en = cyc_i && stb_i && !we_i && !ack_ff;

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= cyc_i && stb_i && !ack_ff;
    end

    // Read mux; unmapped addresses answer with zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_ff <= 32'h0000_0000;
        else if (rd_en)
        begin
            dat_ff <= 32'h0000_0000;
            case (adr_i)
                ADR_AUTOBAUD:   dat_ff[2:0] <= ctrl_ff;
                ADR_INFRARED:   dat_ff[5:0] <= ir_ff;
                ADR_FRACDIV:    dat_ff[7:0] <= fd_ff;
                ADR_DIVISOR:    dat_ff[15:0] <= divisor_ff;
                ADR_IRQ_ENABLE:
                begin
                    dat_ff[IRQ_END_BIT] <= end_en_ff;
                    dat_ff[IRQ_TO_BIT]  <= to_en_ff;
                end
                ADR_IRQ_FLAGS:
                begin
                    dat_ff[IRQ_END_BIT] <= end_flag_ff;
                    dat_ff[IRQ_TO_BIT]  <= to_flag_ff;
                end
                default:        dat_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers; infrared and fractional on byte lane 0, interrupt enables on lane 1
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ir_ff     <= '0;
            fd_ff     <= '{mul: FD_MUL_RESET, add: 4'h0};
            end_en_ff <= 1'b0;
            to_en_ff  <= 1'b0;
        end
        else if (wr_en)
        begin
            if (adr_i == ADR_INFRARED && sel_i[0])
                ir_ff <= dat_i[5:0];
            if (adr_i == ADR_FRACDIV && sel_i[0])
                fd_ff <= dat_i[7:0];
            if (adr_i == ADR_IRQ_ENABLE && sel_i[1])
            begin
                end_en_ff <= dat_i[IRQ_END_BIT];
                to_en_ff  <= dat_i[IRQ_TO_BIT];
            end
        end
    end

    // Control bits; hardware clear of start outranks nothing software does at once
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_ff <= '0;
        else if (wr_en && adr_i == ADR_AUTOBAUD && sel_i[0])
        begin
            ctrl_ff.start   <= dat_i[AB_START_BIT];
            ctrl_ff.mode    <= dat_i[AB_MODE_BIT];
            ctrl_ff.restart <= dat_i[AB_RESTART_BIT];
        end
        else if (done_ok || (done_to && !ctrl_ff.restart))
            ctrl_ff.start <= 1'b0;
    end

    // Divisor latch: software write or measured load at the stop edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            divisor_ff <= DIV_RESET;
        else if (done_ok)
            divisor_ff <= measured;
        else if (wr_en && adr_i == ADR_DIVISOR)
        begin
            if (sel_i[0])
                divisor_ff[7:0] <= dat_i[7:0];
            if (sel_i[1])
                divisor_ff[15:8] <= dat_i[15:8];
        end
    end

    // Sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            end_flag_ff <= 1'b0;
            to_flag_ff  <= 1'b0;
        end
        else
        begin
            if (done_ok && end_en_ff)
                end_flag_ff <= 1'b1;
            else if (wr_en && adr_i == ADR_AUTOBAUD && sel_i[1] && dat_i[AB_END_CLR_BIT])
                end_flag_ff <= 1'b0;
            if (done_to && to_en_ff)
                to_flag_ff <= 1'b1;
            else if (wr_en && adr_i == ADR_AUTOBAUD && sel_i[1] && dat_i[AB_TO_CLR_BIT])
                to_flag_ff <= 1'b0;
        end
    end

    // Receive pin synchroniser
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end
        else
        begin
            rx_meta_ff <= rx_pin_i;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    // Input inversion applies to the receive side only
    assign rx_in  = rx_sync_ff ^ ir_ff.inv;
    // In infrared mode a pulse becomes a zero stretched to one bit time
    assign rx_ser = ir_ff.en ? !(rx_in || irx_cnt_ff != 5'h00) : rx_in;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irx_cnt_ff <= 5'h00;
        else if (ir_ff.en && rx_in)
            irx_cnt_ff <= IR_RX_TICKS;
        else if (baud16 && irx_cnt_ff != 5'h00)
            irx_cnt_ff <= irx_cnt_ff - 5'h01;
    end

    // Edge detection on the decoded serial line
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rx_prev_ff <= 1'b1;
        else
            rx_prev_ff <= rx_ser;
    end

    assign rx_fall = rx_prev_ff && !rx_ser;
    assign rx_rise = !rx_prev_ff && rx_ser;

    // Fractional prescaler swallows a tick on each accumulator wrap
    assign acc_sum  = {1'b0, acc_ff} + {1'b0, fd_ff.add};
    assign acc_wrap = acc_sum >= {1'b0, fd_ff.mul};
    assign pre_tick = (fd_ff.add == 4'h0) || !acc_wrap;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || fd_ff.add == 4'h0)
            acc_ff <= 4'h0;
        else if (acc_wrap)
            acc_ff <= 4'((acc_sum - {1'b0, fd_ff.mul}));
        else
            acc_ff <= acc_sum[3:0];
    end

    // Divisor counter gives the 16x baud tick; zero divisor acts as one
    assign baud16 = pre_tick && div_cnt_ff == 16'h0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            div_cnt_ff <= 16'h0000;
        else if (pre_tick)
        begin
            if (div_cnt_ff == 16'h0000)
                div_cnt_ff <= (divisor_ff == 16'h0000) ? 16'h0000 : divisor_ff - 16'h0001;
            else
                div_cnt_ff <= div_cnt_ff - 16'h0001;
        end
    end

    // Measurement state machine
    assign ab_busy   = state_ff != UABIR_IDLE;
    assign rate_tick = rate_pre_ff == OVERSAMPLE_M1;
    assign overflow  = state_ff == UABIR_MEASURE && rate_tick && rate_cnt_ff == 16'hFFFF;
    assign stop_edge = ctrl_ff.mode ? rx_rise : rx_fall;
    assign done_ok   = state_ff == UABIR_MEASURE && stop_edge && !overflow && ctrl_ff.start;
    assign done_to   = overflow && ctrl_ff.start;
    // Mode 0 spans two bits, so halve the count of 16-clock units
    assign measured  = ctrl_ff.mode ? rate_cnt_ff : {1'b0, rate_cnt_ff[15:1]};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_ff <= UABIR_IDLE;
        else
        begin
            case (state_ff)
                UABIR_IDLE:
                    if (ctrl_ff.start)
                        state_ff <= UABIR_WAIT_FALL;
                UABIR_WAIT_FALL:
                    if (!ctrl_ff.start)
                        state_ff <= UABIR_IDLE;
                    else if (rx_fall)
                        state_ff <= UABIR_MEASURE;
                UABIR_MEASURE:
                    if (!ctrl_ff.start || done_ok)
                        state_ff <= UABIR_IDLE;
                    else if (done_to)
                        state_ff <= ctrl_ff.restart ? UABIR_WAIT_FALL : UABIR_IDLE;
                default:
                    state_ff <= UABIR_IDLE;
            endcase
        end
    end

    // Rate counter counts clock cycles in units of sixteen from the start edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_ff != UABIR_MEASURE)
        begin
            rate_pre_ff <= 4'h0;
            rate_cnt_ff <= 16'h0000;
        end
        else
        begin
            rate_pre_ff <= rate_pre_ff + 4'h1;
            if (rate_tick)
                rate_cnt_ff <= rate_cnt_ff + 16'h0001;
        end
    end

    // Shift register reset pulse when a measurement is armed
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rsr_reset_ff <= 1'b0;
        else
            rsr_reset_ff <= state_ff == UABIR_IDLE && ctrl_ff.start;
    end

    // Burst of clock-rate pulses captures the start bit
    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_ff != UABIR_MEASURE)
            burst_ff <= BURST_PULSES;
        else if (burst_ff != 5'h00)
            burst_ff <= burst_ff - 5'h01;
    end

    // Baud input: held low while armed, burst while measuring, normal otherwise
    always_comb
    begin
        case (state_ff)
            UABIR_WAIT_FALL: rsr_baud_o = 1'b0;
            UABIR_MEASURE:   rsr_baud_o = burst_ff != 5'h00;
            default:         rsr_baud_o = baud16;
        endcase
    end

    // Fixed pulse width doubles per code step from two clocks
    assign fix_width = IR_FIX_BASE << ir_ff.div;

    // Transmit pulse counter; standard width counts 16x ticks, fixed counts clocks
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !ir_ff.en)
            pulse_cnt_ff <= 9'h000;
        else if (tx_bit_start_i && !tx_serial_i)
            pulse_cnt_ff <= ir_ff.fix ? fix_width : IR_STD_TICKS;
        else if (pulse_cnt_ff != 9'h000 && (ir_ff.fix || baud16))
            pulse_cnt_ff <= pulse_cnt_ff - 9'h001;
    end

    // Transmit pin is never inverted; registered to keep it glitch free
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_pin_ff <= 1'b1;
        else if (ir_ff.en)
            tx_pin_ff <= (tx_bit_start_i && !tx_serial_i) || pulse_cnt_ff > 9'h001;
        else
            tx_pin_ff <= tx_serial_i;
    end

    // Outputs
    assign dat_o                  = dat_ff;
    assign ack_o                  = ack_ff;
    assign tx_pin_o               = tx_pin_ff;
    assign rx_serial_o            = rx_ser;
    assign rsr_reset_o            = rsr_reset_ff;
    assign divisor_o              = divisor_ff;
    assign end_measure_irq_flag_o = end_flag_ff;
    assign timeout_irq_flag_o     = to_flag_ff;

    // Checks beside the logic they guard
    a_end_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && adr_i == ADR_AUTOBAUD && sel_i[1] && dat_i[AB_END_CLR_BIT] && !done_ok
        |=> !end_flag_ff)
        else $error("completion flag not cleared");
    a_to_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && adr_i == ADR_AUTOBAUD && sel_i[1] && dat_i[AB_TO_CLR_BIT] && !done_to
        |=> !to_flag_ff)
        else $error("time-out flag not cleared");
    a_abort_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        ab_busy && !ctrl_ff.start |=> state_ff == UABIR_IDLE)
        else $error("abort did not stop measurement");
    a_start_self_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok && !wr_en |=> !ctrl_ff.start)
        else $error("start bit did not clear on completion");
    a_load_divisor: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok |=> divisor_ff == $past(measured))
        else $error("divisor not loaded at stop edge");
    a_end_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ok && end_en_ff |=> end_flag_ff)
        else $error("completion flag not set");
    a_to_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(to_flag_ff) |-> $past(done_to) && $past(to_en_ff))
        else $error("time-out flag set without cause");
    a_restart_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        done_to && ctrl_ff.restart && !wr_en |=> state_ff == UABIR_WAIT_FALL)
        else $error("no restart after time-out");
    a_burst_count: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == UABIR_WAIT_FALL ##1 state_ff == UABIR_MEASURE
        |-> rsr_baud_o [*8] ##1 rsr_baud_o [*8] ##1 (!rsr_baud_o || state_ff != UABIR_MEASURE))
        else $error("start bit burst is not sixteen pulses");
    a_rx_invert: assert property (@(posedge clk_i) disable iff (rst_i)
        !ir_ff.en |-> rx_serial_o == ($past(rx_pin_i, 2) ^ ir_ff.inv))
        else $error("receive inversion wrong");
    a_tx_plain: assert property (@(posedge clk_i) disable iff (rst_i)
        !ir_ff.en ##1 !ir_ff.en |-> tx_pin_o == $past(tx_serial_i))
        else $error("standard mode transmit altered");
    a_fix_width: assert property (@(posedge clk_i) disable iff (rst_i)
        ir_ff.en && ir_ff.fix && ir_ff.div == 3'h0 && tx_bit_start_i && !tx_serial_i
        ##1 !tx_bit_start_i [*2] |-> ##1 !tx_pin_o)
        else $error("fixed pulse too long");

    c_measure_ok: cover property (@(posedge clk_i) disable iff (rst_i) done_ok && end_en_ff);
    c_timeout: cover property (@(posedge clk_i) disable iff (rst_i) done_to);
    c_mode1_done: cover property (@(posedge clk_i) disable iff (rst_i) done_ok && ctrl_ff.mode);
    c_ir_pulse: cover property (@(posedge clk_i) disable iff (rst_i) ir_ff.en && $rose(tx_pin_o));

endmodule

/* usart_autobaud_irda_bench.sv */
// Self-checking bench for the auto-baud and infrared block
`timescale 1ns/1ps
module usart_autobaud_irda_bench;
    import uabir_pkg::*;

    // Register row: address, write value, read-back, value after reset
    typedef struct {
        logic [31:0] adr;
        logic [31:0] wdat;
        logic [31:0] exp;
        logic [31:0] rst;
    } uabir_row_s;

    // Design inputs and outputs
    logic        clk_i          = 1'h0;
    logic        rst_i          = 1'h1;
    logic        cyc_i          = 1'h0;
    logic        stb_i          = 1'h0;
    logic        we_i           = 1'h0;
    logic [31:0] adr_i          = 32'h0;
    logic [3:0]  sel_i          = 4'h0;
    logic [31:0] dat_i          = 32'h0;
    logic        tx_serial_i    = 1'h1;
    logic        tx_bit_start_i = 1'h0;
    logic        rx_pin;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        tx_pin_o;
    logic        rx_serial_o;
    logic [15:0] divisor_o;
    logic        end_flag;
    logic        to_flag;
    logic        rsr_reset;
    // Bench state
    int          bad_count = 0;
    int          checked   = 0;
    int          cycles    = 0;
    logic [31:0] rd;
    uabir_row_s  rows [7];

    uabir_top dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .rx_pin_i(rx_pin), .tx_pin_o, .tx_serial_i, .tx_bit_start_i, .rx_serial_o,
        .rsr_baud_o(), .rsr_reset_o(rsr_reset), .divisor_o, .end_measure_irq_flag_o(end_flag),
        .timeout_irq_flag_o(to_flag)
    );

    uabir_terminal term (
        .clk_i(clk_i),
        .rx_o (rx_pin)
    );

    // Clock at 100 MHz
    always #5 clk_i = ~clk_i;

    // Hang guard, well above the length of the whole sequence
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic single cycle; request held until ack is sampled, data taken at that edge
    task automatic wb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i  <= wr;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'h1);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask

    // One measurement of an 'A' whose bit lasts a little over 16 x dv clocks
    task automatic autobaud(input logic mode, input logic [15:0] dv, input logic en);
        wb(1'h1, ADR_IRQ_ENABLE, {22'h0, 1'h1, en, 8'h0});
        wb(1'h1, ADR_DIVISOR, 32'h1);
        wb(1'h1, ADR_AUTOBAUD, {30'h0, mode, 1'h1});
        // Shift register reset pulse lands one cycle after arming
        repeat (2) @(negedge clk_i);
        chk("arm reset", {31'h0, rsr_reset}, 32'h1);
        term.send(8'h41, 16 * dv + 8);
        wb(1'h0, ADR_AUTOBAUD, 32'h0);
        chk("start bit", rd, {30'h0, mode, 1'h0});
        chk("divisor", {16'h0, divisor_o}, {16'h0, dv});
        chk("end flag", {31'h0, end_flag}, {31'h0, en});
        chk("time-out flag", {31'h0, to_flag}, 32'h0);
    endtask

    // Count infrared pin high cycles after one bit start
    task automatic ir_pulse(input logic [2:0] code, input logic bitval, input logic [31:0] exp);
        int n;
        n = 0;
        wb(1'h1, ADR_INFRARED, {26'h0, code, 3'h5});
        @(posedge clk_i);
        tx_serial_i    <= bitval;
        tx_bit_start_i <= 1'h1;
        @(posedge clk_i);
        tx_bit_start_i <= 1'h0;
        repeat (300)
        begin
            @(negedge clk_i);
            if (tx_pin_o === 1'h1)
                n++;
        end
        @(posedge clk_i);
        tx_serial_i <= 1'h1;
        chk("ir pulse", 32'(n), exp);
    endtask

    // Main sequence
    initial
    begin
        rows = '{
            '{ADR_AUTOBAUD,   32'h0000_0306, 32'h0000_0006, 32'h0},
            '{ADR_INFRARED,   32'h0000_003F, 32'h0000_003F, 32'h0},
            '{ADR_FRACDIV,    32'h0000_0030, 32'h0000_0030, 32'h0000_0010},
            '{ADR_DIVISOR,    32'h0000_A5C3, 32'h0000_A5C3, 32'h0000_0001},
            '{ADR_IRQ_ENABLE, 32'h0000_0300, 32'h0000_0300, 32'h0},
            '{ADR_IRQ_FLAGS,  32'h0000_0300, 32'h0,         32'h0},
            '{32'h4000_804C,  32'hFFFF_FFFF, 32'h0,         32'h0}};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (rows[i])
        begin
            wb(1'h1, rows[i].adr, rows[i].wdat);
            wb(1'h0, rows[i].adr, 32'h0);
            chk("register", rd, rows[i].exp);
        end
        // A second reset in mid-run restores every register
        @(posedge clk_i);
        rst_i <= 1'h1;
        @(posedge clk_i);
        rst_i <= 1'h0;
        foreach (rows[i])
        begin
            wb(1'h0, rows[i].adr, 32'h0);
            chk("reset value", rd, rows[i].rst);
        end
        // Mode 1 with completion flag enabled, then the clear bits
        autobaud(1'h1, 16'h0006, 1'h1);
        wb(1'h1, ADR_AUTOBAUD, 32'h0000_0200);
        repeat (2) @(negedge clk_i);
        chk("end kept", {31'h0, end_flag}, 32'h1);
        wb(1'h1, ADR_AUTOBAUD, 32'h0000_0100);
        repeat (2) @(negedge clk_i);
        chk("end cleared", {31'h0, end_flag}, 32'h0);
        // Mode 0 with the flag disabled must stay quiet
        autobaud(1'h0, 16'h0005, 1'h0);
        // Start withdrawn before the character: divisor untouched
        wb(1'h1, ADR_AUTOBAUD, 32'h0000_0003);
        wb(1'h1, ADR_AUTOBAUD, 32'h0);
        term.send(8'h41, 200);
        chk("abort divisor", {16'h0, divisor_o}, 32'h5);
        // Standard mode with input inversion; output stays plain
        wb(1'h1, ADR_INFRARED, 32'h0000_0002);
        @(posedge clk_i);
        tx_serial_i <= 1'h0;
        repeat (3) @(negedge clk_i);
        chk("rx invert", {31'h0, rx_serial_o}, 32'h0);
        chk("tx plain", {31'h0, tx_pin_o}, 32'h0);
        @(posedge clk_i);
        tx_serial_i <= 1'h1;
        // Fixed widths, and no pulse for a one bit
        ir_pulse(3'h0, 1'h0, 32'h2);
        ir_pulse(3'h3, 1'h0, 32'h10);
        ir_pulse(3'h7, 1'h0, 32'h100);
        ir_pulse(3'h7, 1'h1, 32'h0);
        test_done();
    end
endmodule
